// ---- dsi_pkg.sv ----
// constants, register map and types shared by the safe input evaluator
package dsi_pkg;

    // clock and time base
    localparam int CLK_PERIOD_NS = 25;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIME_W_DEF = 16;

    // input and output counts of the module
    localparam int NUM_INPUTS_DEF = 10;
    localparam int NUM_OUTPUTS_DEF = 4;
    localparam int NUM_PATHS_DEF = 2;
    localparam int GROUP_A_LAST = 4;

    // dark time of a dynamic supply during the forced check, in us
    localparam logic [15:0] TEST_OFF_US_DEF = 16'h07d0;

    // register byte offsets
    localparam logic [5:0] OFS_CTRL = 6'h00;
    localparam logic [5:0] OFS_MODE = 6'h04;
    localparam logic [5:0] OFS_WINDOW = 6'h08;
    localparam logic [5:0] OFS_SUPPRESS = 6'h0c;
    localparam logic [5:0] OFS_ACK_SEL = 6'h10;
    localparam logic [5:0] OFS_STATUS = 6'h14;
    localparam logic [5:0] OFS_FAULT = 6'h18;
    localparam logic [5:0] OFS_ACK = 6'h1c;
    localparam logic [5:0] OFS_CHAN = 6'h20;

    // field positions
    localparam int CTRL_TEST_BIT = 0;
    localparam int CTRL_BUSY_BIT = 1;
    localparam int ACK_CU_BIT = 0;
    localparam int FAULT_TEST_BIT = 16;
    localparam int FAULT_ARMED_BIT = 17;
    localparam int ACK_SEL_W = 4;

    // reset values
    localparam logic [15:0] WINDOW_RESET = 16'h01f4;
    localparam logic [15:0] SUPPRESS_RESET = 16'h0001;
    localparam logic [3:0] ACK_SEL_NONE = 4'hf;

    // forced checking sequence
    typedef enum logic [2:0] {
        T_IDLE = 3'b000,
        T_OFF_A = 3'b001,
        T_ON_A = 3'b010,
        T_OFF_B = 3'b011,
        T_ON_B = 3'b100
    } test_state_t;

endpackage

// ---- input_filter.sv ----
// suppression filter for one input channel
`timescale 1ns/1ps
module input_filter import dsi_pkg::*; #(
    parameter int TIME_W = TIME_W_DEF
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // time base and setting
    input wire logic tick,
    input wire logic [TIME_W-1:0] suppress,
    // channel
    input wire logic raw,
    output logic filtered
);

    typedef struct packed {
        logic stable;
        logic [TIME_W-1:0] cnt;
    } filt_state_t;

    filt_state_t s;
    filt_state_t next_s;

    // a new level is taken only after it stood longer than the setting
    always_comb begin
        next_s = s;
        if (raw == s.stable) begin
            next_s.cnt = '0;
        end else if (tick) begin
            if (s.cnt >= suppress) begin
                next_s.stable = raw;
                next_s.cnt = '0;
            end else begin
                next_s.cnt = s.cnt + 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign filtered = s.stable;

    a_filter_follows: assert property (@(posedge clk_sys) disable iff (!resetn)
        $changed(filtered) |-> filtered == $past(raw) && $past(tick))
        else $error("filter output changed without a settled input");

endmodule

// ---- dual_input_pair.sv ----
// discrepancy check and freeze for one dual channel input
`timescale 1ns/1ps
module dual_input_pair import dsi_pkg::*; #(
    parameter int TIME_W = TIME_W_DEF
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // time base and settings
    input wire logic tick,
    input wire logic antivalent,
    input wire logic [TIME_W-1:0] window,
    input wire logic hold,
    input wire logic ack_pulse,
    // filtered channels
    input wire logic ch_a,
    input wire logic ch_b,
    // evaluated result
    output logic chan_a_state,
    output logic chan_b_state,
    output logic run,
    output logic fault
);

    typedef struct packed {
        logic frozen;
        logic fault;
        logic [TIME_W-1:0] cnt;
    } pair_state_t;

    pair_state_t s;
    pair_state_t next_s;
    logic consistent;
    logic expire;

    // the pair agrees when it shows the pattern the contact mode allows
    assign consistent = antivalent ? (ch_a != ch_b) : (ch_a == ch_b);
    assign expire = !consistent && !hold && !s.fault && (s.cnt >= window);

    // window count, fault and freeze; a new fault beats a release
    always_comb begin
        next_s = s;
        if (consistent || hold) begin
            next_s.cnt = '0;
        end else if (tick && !s.fault && s.cnt < window) begin
            next_s.cnt = s.cnt + 1'b1;
        end
        if (expire) begin
            next_s.fault = 1'b1;
            next_s.frozen = 1'b1;
        end else if (ack_pulse && consistent) begin
            next_s.fault = 1'b0;
            next_s.frozen = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // frozen channels read zero, i.e. safety function selected
    assign chan_a_state = s.frozen ? 1'b0 : ch_a;
    assign chan_b_state = s.frozen ? 1'b0 : ch_b;
    // run means the safety function is not selected
    assign run = !s.frozen && ch_a && (antivalent ? !ch_b : ch_b);
    assign fault = s.fault;

    a_fault_cause: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(s.fault) |-> $past(!consistent && !hold))
        else $error("mismatch fault without a disagreeing pair");
    a_frozen_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
        s.frozen |-> !chan_a_state && !chan_b_state && !run)
        else $error("frozen input does not read zero");
    a_release_ok: assert property (@(posedge clk_sys) disable iff (!resetn)
        $fell(s.frozen) |-> $past(ack_pulse) && $past(consistent))
        else $error("input released without acknowledgment");
    a_fault_sticky: assert property (@(posedge clk_sys) disable iff (!resetn)
        s.fault && !ack_pulse |=> s.fault)
        else $error("mismatch fault cleared on its own");
    c_pair_fault: cover property (@(posedge clk_sys) disable iff (!resetn)
        $rose(s.fault));
    c_pair_release: cover property (@(posedge clk_sys) disable iff (!resetn)
        $fell(s.frozen));

endmodule

// ---- dual_channel_safe_input_eval.sv ----
// ten dual channel failsafe inputs with register slave and forced check
//
// What this block does
// - each failsafe input is a pair of channels judged together into one.
// - the module carries ten dual inputs; its four outputs lie elsewhere.
// - a per input contact mode picks equivalent or antivalent wiring.
// - equivalent mode selects safety when either channel reads zero.
// - antivalent mode selects safety when channel one is 0 and two is 1.
// - both channels must reach a legal pattern within one shared window.
// - disagreement past the window raises a fault cleared only safely.
// - on mismatch both channels are frozen at zero until a safe ack.
// - every channel passes a filter with a programmable suppression time.
// - each channel status is readable and paths are combined by AND.
// - faults clear at power up or on ack input fall plus a control ack.
// - the forced check switches the sensor supplies off and on again.
`timescale 1ns/1ps
module dual_channel_safe_input_eval import dsi_pkg::*; #(
    parameter int NUM_INPUTS = NUM_INPUTS_DEF,
    parameter int NUM_PATHS = NUM_PATHS_DEF,
    parameter int TIME_W = TIME_W_DEF,
    parameter logic [TIME_W-1:0] TEST_OFF_US = TEST_OFF_US_DEF
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // register bus
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // sensor channels
    input wire logic [NUM_INPUTS-1:0] input_ch_a,
    input wire logic [NUM_INPUTS-1:0] input_ch_b,
    // evaluated inputs and faults
    output logic [NUM_INPUTS-1:0] failsafe_dual_input,
    output logic [NUM_INPUTS-1:0] channel_mismatch_fault,
    // sensor supplies
    output logic dynamic_supply_a,
    output logic dynamic_supply_b,
    output logic test_busy
);

    localparam int TICK_W = $clog2(TICK_CYCLES);
    localparam int CHAN_W = 2 * NUM_INPUTS;

    typedef struct packed {
        logic waitrequest;
        logic [31:0] readdata;
        logic [NUM_INPUTS-1:0] input_contact_mode;
        logic [TIME_W-1:0] discrepancy_window;
        logic [TIME_W-1:0] input_suppression_time;
        logic [ACK_SEL_W-1:0] safe_ack_input_select;
        logic [TICK_W-1:0] tick_cnt;
        logic tick;
        logic ack_prev;
        logic ack_armed;
        logic ack_pulse;
        test_state_t test_state;
        logic [TIME_W-1:0] test_cnt;
        logic test_fail;
        logic busy;
        logic supply_a;
        logic supply_b;
        logic [NUM_INPUTS-1:0] fs_input;
        logic [NUM_INPUTS-1:0] fault_out;
        logic [CHAN_W-1:0] input_channel_status;
    } state_t;

    state_t s;
    state_t next_s;

    // per path results
    logic [NUM_PATHS-1:0][NUM_INPUTS-1:0] filt_a;
    logic [NUM_PATHS-1:0][NUM_INPUTS-1:0] filt_b;
    logic [NUM_PATHS-1:0][NUM_INPUTS-1:0] st_a;
    logic [NUM_PATHS-1:0][NUM_INPUTS-1:0] st_b;
    logic [NUM_PATHS-1:0][NUM_INPUTS-1:0] run_p;
    logic [NUM_PATHS-1:0][NUM_INPUTS-1:0] flt_p;
    // combined results
    logic [NUM_INPUTS-1:0] run_and;
    logic [NUM_INPUTS-1:0] st_a_and;
    logic [NUM_INPUTS-1:0] st_b_and;
    logic [NUM_INPUTS-1:0] fault_or;
    logic [NUM_INPUTS-1:0] group_a_mask;
    logic hold;
    logic req;
    logic bus_take;

    assign hold = (s.test_state != T_IDLE);
    assign req = avs_read || avs_write;
    assign bus_take = req && !s.waitrequest;

    // two independent evaluating paths, each with filters and pair checks
    for (genvar p = 0; p < NUM_PATHS; p++) begin : g_path
        for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_in
            input_filter #(
                .TIME_W(TIME_W)
            ) u_filt_a (
                .clk_sys(clk_sys),
                .resetn(resetn),
                .tick(s.tick),
                .suppress(s.input_suppression_time),
                .raw(input_ch_a[i]),
                .filtered(filt_a[p][i])
            );
            input_filter #(
                .TIME_W(TIME_W)
            ) u_filt_b (
                .clk_sys(clk_sys),
                .resetn(resetn),
                .tick(s.tick),
                .suppress(s.input_suppression_time),
                .raw(input_ch_b[i]),
                .filtered(filt_b[p][i])
            );
            // the pair is judged together into one result
            dual_input_pair #(
                .TIME_W(TIME_W)
            ) u_pair (
                .clk_sys(clk_sys),
                .resetn(resetn),
                .tick(s.tick),
                .antivalent(s.input_contact_mode[i]),
                .window(s.discrepancy_window),
                .hold(hold),
                .ack_pulse(s.ack_pulse),
                .ch_a(filt_a[p][i]),
                .ch_b(filt_b[p][i]),
                .chan_a_state(st_a[p][i]),
                .chan_b_state(st_b[p][i]),
                .run(run_p[p][i]),
                .fault(flt_p[p][i])
            );
        end
    end

    // paths are joined by AND for states, by OR for faults
    always_comb begin
        run_and = '1;
        st_a_and = '1;
        st_b_and = '1;
        fault_or = '0;
        for (int p = 0; p < NUM_PATHS; p++) begin
            run_and = run_and & run_p[p];
            st_a_and = st_a_and & st_a[p];
            st_b_and = st_b_and & st_b[p];
            fault_or = fault_or | flt_p[p];
        end
    end

    // inputs wired to the first dynamic supply
    assign group_a_mask = NUM_INPUTS'((1 << (GROUP_A_LAST + 1)) - 1);

    // merges write data into a register under the byte enables
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = data[8*b +: 8];
            end
        end
        return r;
    endfunction

    // next state of the whole block
    always_comb begin
        logic [31:0] wr_mode;
        logic [31:0] wr_win;
        logic [31:0] wr_sup;
        logic [31:0] wr_sel;
        logic [31:0] wr_data;
        logic ack_level;
        logic cu_ack;
        logic test_start;
        logic test_end;
        next_s = s;
        wr_mode = merge(32'(s.input_contact_mode), avs_writedata,
                        avs_byteenable);
        wr_win = merge(32'(s.discrepancy_window), avs_writedata,
                       avs_byteenable);
        wr_sup = merge(32'(s.input_suppression_time), avs_writedata,
                       avs_byteenable);
        wr_sel = merge(32'(s.safe_ack_input_select), avs_writedata,
                       avs_byteenable);
        wr_data = merge(32'h0000_0000, avs_writedata, avs_byteenable);
        ack_level = (s.safe_ack_input_select < ACK_SEL_W'(NUM_INPUTS)) ?
                    s.fs_input[s.safe_ack_input_select] : 1'b1;
        cu_ack = 1'b0;
        test_start = 1'b0;
        test_end = (s.test_cnt >= TEST_OFF_US);

        // microsecond time base
        next_s.tick = 1'b0;
        if (s.tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
            next_s.tick_cnt = '0;
            next_s.tick = 1'b1;
        end else begin
            next_s.tick_cnt = s.tick_cnt + 1'b1;
        end

        // bus: answer one cycle after the request, act when it is taken
        next_s.waitrequest = !(req && s.waitrequest);
        if (req && s.waitrequest && avs_read) begin
            case (avs_address)
                OFS_CTRL: next_s.readdata = 32'(hold) << CTRL_BUSY_BIT;
                OFS_MODE: next_s.readdata = 32'(s.input_contact_mode);
                OFS_WINDOW: next_s.readdata = 32'(s.discrepancy_window);
                OFS_SUPPRESS: next_s.readdata = 32'(s.input_suppression_time);
                OFS_ACK_SEL: next_s.readdata = 32'(s.safe_ack_input_select);
                OFS_STATUS: next_s.readdata = 32'(s.fs_input);
                OFS_FAULT: begin
                    next_s.readdata = 32'(s.fault_out);
                    next_s.readdata[FAULT_TEST_BIT] = s.test_fail;
                    next_s.readdata[FAULT_ARMED_BIT] = s.ack_armed;
                end
                OFS_CHAN: next_s.readdata = 32'(s.input_channel_status);
                default: next_s.readdata = '0;
            endcase
        end
        if (bus_take && avs_write) begin
            case (avs_address)
                OFS_CTRL: test_start = wr_data[CTRL_TEST_BIT];
                OFS_MODE: next_s.input_contact_mode =
                    wr_mode[NUM_INPUTS-1:0];
                OFS_WINDOW: next_s.discrepancy_window =
                    wr_win[TIME_W-1:0];
                OFS_SUPPRESS: next_s.input_suppression_time =
                    wr_sup[TIME_W-1:0];
                OFS_ACK_SEL: next_s.safe_ack_input_select =
                    wr_sel[ACK_SEL_W-1:0];
                OFS_ACK: cu_ack = wr_data[ACK_CU_BIT];
                default: ;
            endcase
        end

        // acknowledge: falling edge of the chosen input arms, control acks
        next_s.ack_prev = ack_level;
        next_s.ack_pulse = cu_ack && s.ack_armed;
        if (next_s.ack_pulse) begin
            next_s.ack_armed = 1'b0;
        end
        if (s.ack_prev && !ack_level) begin
            next_s.ack_armed = 1'b1;
        end
        if (s.ack_pulse) begin
            next_s.test_fail = 1'b0;
        end

        // forced check: each supply dark, group checked, then restored
        if (s.tick && hold && !test_end) begin
            next_s.test_cnt = s.test_cnt + 1'b1;
        end
        case (s.test_state)
            T_IDLE: begin
                if (test_start) begin
                    next_s.test_state = T_OFF_A;
                    next_s.supply_a = 1'b0;
                    next_s.test_cnt = '0;
                end
            end
            T_OFF_A: begin
                if (test_end) begin
                    if (|((st_a_and | st_b_and) & group_a_mask)) begin
                        next_s.test_fail = 1'b1;
                    end
                    next_s.test_state = T_ON_A;
                    next_s.supply_a = 1'b1;
                    next_s.test_cnt = '0;
                end
            end
            T_ON_A: begin
                if (test_end) begin
                    next_s.test_state = T_OFF_B;
                    next_s.supply_b = 1'b0;
                    next_s.test_cnt = '0;
                end
            end
            T_OFF_B: begin
                if (test_end) begin
                    if (|((st_a_and | st_b_and) & ~group_a_mask)) begin
                        next_s.test_fail = 1'b1;
                    end
                    next_s.test_state = T_ON_B;
                    next_s.supply_b = 1'b1;
                    next_s.test_cnt = '0;
                end
            end
            T_ON_B: begin
                if (test_end) begin
                    next_s.test_state = T_IDLE;
                    next_s.test_cnt = '0;
                end
            end
            default: begin
                next_s.test_state = T_IDLE;
                next_s.supply_a = 1'b1;
                next_s.supply_b = 1'b1;
            end
        endcase

        // registered results
        next_s.fs_input = run_and;
        next_s.fault_out = fault_or;
        next_s.busy = (next_s.test_state != T_IDLE);
        for (int i = 0; i < NUM_INPUTS; i++) begin
            next_s.input_channel_status[2*i] = st_a_and[i];
            next_s.input_channel_status[2*i+1] = st_b_and[i];
        end
    end

    // state register; power up clears every fault
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            s <= '0;
            s.waitrequest <= 1'b1;
            s.discrepancy_window <= WINDOW_RESET;
            s.input_suppression_time <= SUPPRESS_RESET;
            s.safe_ack_input_select <= ACK_SEL_NONE;
            s.ack_prev <= 1'b1;
            s.test_state <= T_IDLE;
            s.supply_a <= 1'b1;
            s.supply_b <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from the state register
    assign avs_readdata = s.readdata;
    assign avs_waitrequest = s.waitrequest;
    assign failsafe_dual_input = s.fs_input;
    assign channel_mismatch_fault = s.fault_out;
    assign dynamic_supply_a = s.supply_a;
    assign dynamic_supply_b = s.supply_b;
    assign test_busy = s.busy;

    a_bus_answer: assert property (@(posedge clk_sys) disable iff (!resetn)
        req && s.waitrequest |=> !s.waitrequest ##1 s.waitrequest)
        else $error("bus answer not one cycle after request");
    a_ack_armed: assert property (@(posedge clk_sys) disable iff (!resetn)
        s.ack_pulse |-> $past(s.ack_armed) && $past(bus_take))
        else $error("acknowledge without prior input edge");
    a_status_and: assert property (@(posedge clk_sys) disable iff (!resetn)
        ##1 s.fs_input == $past(run_and))
        else $error("status is not the AND of both paths");
    a_supply_order: assert property (@(posedge clk_sys) disable iff (!resetn)
        !(dynamic_supply_a && dynamic_supply_b) |->
        test_busy && (dynamic_supply_a || dynamic_supply_b))
        else $error("supplies switched off outside the check");
    a_check_start: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(test_busy) |-> !dynamic_supply_a && dynamic_supply_b)
        else $error("forced check did not start on supply a");
    c_check_done: cover property (@(posedge clk_sys) disable iff (!resetn)
        $fell(test_busy));
    c_safe_ack: cover property (@(posedge clk_sys) disable iff (!resetn)
        s.ack_pulse && |s.fault_out);
    c_bus_write: cover property (@(posedge clk_sys) disable iff (!resetn)
        bus_take && avs_write && avs_address == OFS_MODE);

endmodule

// ---- sensor_model.sv ----
// sensor model: contact pattern powered by the dynamic supplies
`timescale 1ns/1ps
module sensor_model (
    // supplies
    input wire logic dynamic_supply_a,
    input wire logic dynamic_supply_b,
    // wanted contact pattern
    input wire logic [9:0] pat_a,
    input wire logic [9:0] pat_b,
    // contacts wired past their supply
    input wire logic [9:0] stuck,
    // channels to the block
    output logic [9:0] ch_a,
    output logic [9:0] ch_b
);
    logic [9:0] pwr;
    // an unpowered contact reads zero
    assign pwr = {{5{dynamic_supply_b}}, {5{dynamic_supply_a}}} | stuck;
    assign ch_a = pat_a & pwr;
    assign ch_b = pat_b & pwr;
endmodule

// ---- dual_channel_safe_input_eval_bench.sv ----
// bench for the dual channel safe input evaluator
`timescale 1ns/1ps
module dual_channel_safe_input_eval_bench;
    import dsi_pkg::*;
    logic clk_sys = 0;
    logic resetn = 0;
    logic [5:0] avs_address = 0;
    logic avs_read = 0;
    logic avs_write = 0;
    logic [31:0] avs_writedata = 0;
    logic [31:0] avs_readdata, got;
    logic avs_waitrequest, sup_a, sup_b, busy;
    logic [9:0] pat_a = 0;
    logic [9:0] pat_b = 0;
    logic [9:0] stuck = 0;
    logic [9:0] ch_a, ch_b, fsi, flt;
    int failures = 0;
    int checked = 0;

    // 40 MHz clock
    always #12.5 clk_sys = ~clk_sys;

    dual_channel_safe_input_eval #(.TEST_OFF_US(16'h0003))
        dual_channel_safe_input_eval_i (
        .clk_sys(clk_sys), .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .input_ch_a(ch_a), .input_ch_b(ch_b), .failsafe_dual_input(fsi),
        .channel_mismatch_fault(flt), .dynamic_supply_a(sup_a),
        .dynamic_supply_b(sup_b), .test_busy(busy));

    sensor_model sensor_model_i (.dynamic_supply_a(sup_a),
        .dynamic_supply_b(sup_b), .pat_a(pat_a), .pat_b(pat_b),
        .stuck(stuck), .ch_a(ch_a), .ch_b(ch_b));

    // one bus cycle, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [5:0] a,
                       input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        got = avs_readdata;
        avs_write <= 0;
        avs_read <= 0;
        @(posedge clk_sys);
    endtask

    // compare and count
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] s);
        checked++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask

    // read a register and compare
    task automatic rdc(input string n, input logic [5:0] a,
                       input logic [31:0] e);
        bus(0, a, 0);
        chk(n, e, got);
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // verdict and end of run
    task automatic end_sim;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // test sequence
    initial begin
        wt(10);
        resetn <= 1;
        @(posedge clk_sys);
        rdc("mode", OFS_MODE, 0);
        rdc("window", OFS_WINDOW, 32'(WINDOW_RESET));
        rdc("suppress", OFS_SUPPRESS, 32'(SUPPRESS_RESET));
        rdc("ack_sel", OFS_ACK_SEL, 32'(ACK_SEL_NONE));
        rdc("unmapped", 6'h24, 0);
        $display("reset test done");
        bus(1, OFS_WINDOW, 32'h14);
        rdc("win set", OFS_WINDOW, 32'h14);
        bus(1, OFS_MODE, 1);
        pat_a <= 10'h3ff;
        pat_b <= 10'h3fe;
        wt(600);
        chk("run", 32'h3ff, 32'(fsi));
        rdc("status", OFS_STATUS, 32'h3ff);
        rdc("chan", OFS_CHAN, 32'hffffd);
        pat_b[3] <= 0;
        wt(40);
        pat_b[3] <= 1;
        wt(200);
        chk("pulse", 0, 32'(flt));
        $display("run test done");
        bus(1, OFS_WINDOW, 5);
        pat_b[1] <= 0;
        wt(150);
        chk("early", 0, 32'(flt));
        wt(350);
        chk("fault", 32'h2, 32'(flt));
        pat_b[1] <= 1;
        wt(300);
        chk("frozen", 32'h3fd, 32'(fsi));
        rdc("chan frz", OFS_CHAN, 32'hffff1);
        $display("mismatch test done");
        bus(1, OFS_ACK_SEL, 2);
        pat_a[2] <= 0;
        pat_b[2] <= 0;
        wt(200);
        pat_a[2] <= 1;
        pat_b[2] <= 1;
        wt(200);
        bus(1, OFS_ACK, 1);
        wt(5);
        chk("ack", 0, 32'(flt));
        chk("release", 32'h3ff, 32'(fsi));
        $display("ack test done");
        bus(1, OFS_CTRL, 1);
        wt(3);
        chk("supply off", 32'h2, {30'h0, busy, sup_a});
        while (sup_b !== 1'b0)
            @(posedge clk_sys);
        chk("supply b", 32'h6, {29'h0, busy, sup_a, sup_b});
        while (busy !== 1'b0)
            @(posedge clk_sys);
        chk("supplies on", 32'h3, {30'h0, sup_a, sup_b});
        rdc("busy", OFS_CTRL, 0);
        rdc("fault reg", OFS_FAULT, 32'h0002_0000);
        $display("forced check test done");
        stuck <= 10'h020;
        bus(1, OFS_CTRL, 1);
        while (busy !== 1'b0)
            @(posedge clk_sys);
        rdc("test fail", OFS_FAULT, 32'h0003_0000);
        bus(1, OFS_ACK, 1);
        rdc("fail clear", OFS_FAULT, 0);
        stuck <= 0;
        $display("stuck supply test done");
        end_sim();
    end

    // watchdog cuts a hang short
    initial begin
        wt(50000);
        failures++;
        end_sim();
    end
endmodule
